// *** src/kirc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module kirc_top
	import kirc_pkg::*;
#(
	parameter int KEYS = kirc_pkg::KEY_W
) (
	input  wire logic                    core_clk,
	input  wire logic                    reset,
	input  wire logic                    clkEn,
	input  wire kirc_pkg::kirc_bus_t     bus,
	output logic [kirc_pkg::DATA_W-1:0]  rdata,
	input  wire logic [KEYS-1:0]         keyIn,
	input  wire logic [kirc_pkg::DIR_PINS-1:0] retPinIn,
	input  wire logic [kirc_pkg::DIR_PINS-1:0] retPinOut,
	output logic [kirc_pkg::DIR_PINS-1:0] retPinOe_n,
	output logic [kirc_pkg::DIR_PINS-1:0] retPinSeen,
	output logic                         keyIntReq,
	output logic [1:0]                   keyPriority,
	output logic                         irq
);
	import kirc_pkg::*;

	logic [DATA_W-1:0] dir_r;
	logic [DATA_W-1:0] ifl_r;
	logic [DATA_W-1:0] mkl_r;
	logic [DATA_W-1:0] pr0_r;
	logic [DATA_W-1:0] pr1_r;
	logic [DATA_W-1:0] kma_r;
	logic [KMB_W-1:0]  kmb_r;
	logic [DATA_W-1:0] krc_r;
	logic [KEYS-1:0]   kflags_r;
	logic [EV_W-1:0]   ists_r;
	logic [EV_W-1:0]   imsk_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic [KEYS-1:0]   detEn;
	logic [KEYS-1:0]   edgeHit;
	logic              anyHit;
	logic              wrEn;
	logic              rdEn;
	logic              flagUse;
	logic [2*DATA_W-1:0] kfClr;

	assign wrEn = clkEn && bus.wr;
	assign rdEn = clkEn && bus.rd;
	assign flagUse = krc_r[FLAGUSE_BIT];

	assign detEn = KEYS'({kmb_r, kma_r});

	kirc_edge_detect #(
		.WIDTH (KEYS)
	) u_edge (
		.core_clk  (core_clk),
		.reset     (reset),
		.clkEn     (clkEn),
		.pinIn     (keyIn),
		.enable    (detEn),
		.risingSel (krc_r[EDGE_BIT]),
		.edgeHit   (edgeHit)
	);

	assign anyHit = |edgeHit;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			dir_r <= DIR_RST;
		end else if (wrEn && bus.addr == OFF_DIR) begin
			dir_r <= bus.wdata | DIR_FIXED;
		end
	end

	assign retPinOe_n = dir_r[DIR_PINS-1:0];
	// output mode reads back the driven level
	assign retPinSeen = (retPinIn & retPinOe_n) | (retPinOut & ~retPinOe_n);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ifl_r <= ZERO8;
		end else if (clkEn) begin
			if (wrEn && bus.addr == OFF_IFL) begin
				ifl_r <= bus.wdata;
			end
			if (anyHit) begin
				ifl_r[KEY_BIT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			mkl_r <= MASK_RST;
		end else if (wrEn && bus.addr == OFF_MKL) begin
			mkl_r <= bus.wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pr0_r <= PRIO_RST;
			pr1_r <= PRIO_RST;
		end else if (wrEn) begin
			if (bus.addr == OFF_PR0) begin
				pr0_r <= bus.wdata;
			end
			if (bus.addr == OFF_PR1) begin
				pr1_r <= bus.wdata;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			kma_r <= ZERO8;
			kmb_r <= '0;
		end else if (wrEn) begin
			if (bus.addr == OFF_KMA) begin
				kma_r <= bus.wdata;
			end
			if (bus.addr == OFF_KMB) begin
				kmb_r <= bus.wdata[KMB_W-1:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			krc_r <= ZERO8;
		end else if (wrEn && bus.addr == OFF_KRC) begin
			krc_r <= bus.wdata & KRC_MASK;
		end
	end

	// per-pin flag clear mask, low and high halves
	always_comb begin
		kfClr = '0;
		if (wrEn && bus.addr == OFF_KFL) begin
			kfClr[DATA_W-1:0] = bus.wdata;
		end
		if (wrEn && bus.addr == OFF_KFM) begin
			kfClr[2*DATA_W-1:DATA_W] = bus.wdata;
		end
	end

	// per-pin flags: write one clears, hit sets
	always_ff @(posedge core_clk) begin
		if (reset) begin
			kflags_r <= '0;
		end else if (clkEn) begin
			kflags_r <= (kflags_r & ~kfClr[KEYS-1:0]) | (flagUse ? edgeHit : {KEYS{1'b0}});
		end
	end

	// interrupt status: write one clears, event wins
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ists_r <= '0;
			imsk_r <= '0;
		end else if (clkEn) begin
			if (wrEn && bus.addr == OFF_ISTS) begin
				ists_r <= (ists_r & ~bus.wdata[EV_W-1:0]) | EV_W'(anyHit);
			end else begin
				ists_r <= ists_r | EV_W'(anyHit);
			end
			if (wrEn && bus.addr == OFF_IMSK) begin
				imsk_r <= bus.wdata[EV_W-1:0];
			end
		end
	end

	assign keyIntReq = ifl_r[KEY_BIT] && !mkl_r[KEY_BIT];
	assign keyPriority = {pr1_r[KEY_BIT], pr0_r[KEY_BIT]};
	assign irq = |(ists_r & imsk_r);

	always_comb begin
		rdata_nxt = ZERO8;
		unique case (bus.addr)
			OFF_DIR:  rdata_nxt = dir_r;
			OFF_IFL:  rdata_nxt = ifl_r;
			OFF_MKL:  rdata_nxt = mkl_r;
			OFF_PR0:  rdata_nxt = pr0_r;
			OFF_PR1:  rdata_nxt = pr1_r;
			OFF_KMA:  rdata_nxt = kma_r;
			OFF_KMB:  rdata_nxt = DATA_W'(kmb_r);
			OFF_KRC:  rdata_nxt = krc_r;
			OFF_KFL:  rdata_nxt = kflags_r[DATA_W-1:0];
			OFF_KFM:  rdata_nxt = DATA_W'(kflags_r[KEYS-1:DATA_W]);
			OFF_ISTS: rdata_nxt = DATA_W'(ists_r);
			OFF_IMSK: rdata_nxt = DATA_W'(imsk_r);
			default:  rdata_nxt = ZERO8;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdata <= ZERO8;
		end else if (clkEn) begin
			rdata <= rdEn ? rdata_nxt : ZERO8;
		end
	end

	flag_set_a: assert property (@(posedge core_clk) disable iff (reset)
		anyHit |=> ifl_r[KEY_BIT])
		else $error("edge did not set request flag");

	mask_gate_a: assert property (@(posedge core_clk) disable iff (reset)
		mkl_r[KEY_BIT] |-> !keyIntReq)
		else $error("masked request raised");

	prio_map_a: assert property (@(posedge core_clk) disable iff (reset)
		(wrEn && bus.addr == OFF_PR1) |=> keyPriority[1] == $past(bus.wdata[KEY_BIT]))
		else $error("priority high bit not applied");

	prio_low_a: assert property (@(posedge core_clk) disable iff (reset)
		(wrEn && bus.addr == OFF_PR0) |=> keyPriority[0] == $past(bus.wdata[KEY_BIT]))
		else $error("priority low bit not applied");

	pin_gate_a: assert property (@(posedge core_clk) disable iff (reset)
		(edgeHit & ~detEn) == '0)
		else $error("disabled pin detected");

	edge_dir_a: assert property (@(posedge core_clk) disable iff (reset)
		(clkEn && !krc_r[EDGE_BIT] && detEn[0] && $fell(keyIn[0]) && $past(clkEn)) |-> edgeHit[0])
		else $error("falling edge missed");

	edge_rise_a: assert property (@(posedge core_clk) disable iff (reset)
		(clkEn && krc_r[EDGE_BIT] && detEn[0] && $rose(keyIn[0]) && $past(clkEn)) |-> edgeHit[0])
		else $error("rising edge missed");

	dir_oe_a: assert property (@(posedge core_clk) disable iff (reset)
		(wrEn && bus.addr == OFF_DIR) |=> retPinOe_n == $past(bus.wdata[DIR_PINS-1:0]))
		else $error("direction write not applied");

	dir_fixed_a: assert property (@(posedge core_clk) disable iff (reset)
		dir_r[DATA_W-1:DIR_PINS] == DIR_FIXED[DATA_W-1:DIR_PINS])
		else $error("fixed direction bits changed");

	oe_seen_a: assert property (@(posedge core_clk) disable iff (reset)
		(retPinSeen & ~retPinOe_n) == (retPinOut & ~retPinOe_n))
		else $error("driven pin level not seen");

	flag_hold_a: assert property (@(posedge core_clk) disable iff (reset)
		(ifl_r[KEY_BIT] && !(wrEn && bus.addr == OFF_IFL)) |=> ifl_r[KEY_BIT])
		else $error("request flag dropped");

	flag_write_a: assert property (@(posedge core_clk) disable iff (reset)
		(wrEn && bus.addr == OFF_IFL && !anyHit) |=> ifl_r == $past(bus.wdata))
		else $error("request flag write lost");

	flag_read_a: assert property (@(posedge core_clk) disable iff (reset)
		(rdEn && bus.addr == OFF_IFL) |=> rdata == $past(ifl_r))
		else $error("request flag read wrong");

	// read data only after a read
	rdata_idle_a: assert property (@(posedge core_clk) disable iff (reset)
		(clkEn && !rdEn) |=> rdata == ZERO8)
		else $error("read data without read");

	clk_freeze_a: assert property (@(posedge core_clk) disable iff (reset)
		!clkEn |=> ($stable(ifl_r) && $stable(mkl_r) && $stable(kflags_r) && $stable(rdata)))
		else $error("state moved while frozen");

	mask_write_a: assert property (@(posedge core_clk) disable iff (reset)
		(wrEn && bus.addr == OFF_MKL) |=> mkl_r == $past(bus.wdata))
		else $error("mask write not applied");

	req_raise_a: assert property (@(posedge core_clk) disable iff (reset)
		(anyHit && !mkl_r[KEY_BIT] && !(wrEn && bus.addr == OFF_MKL)) |=> keyIntReq)
		else $error("unmasked request not raised");

	kma_write_a: assert property (@(posedge core_clk) disable iff (reset)
		(wrEn && bus.addr == OFF_KMA) |=> detEn[DATA_W-1:0] == $past(bus.wdata))
		else $error("low detect enables not applied");

	kmb_write_a: assert property (@(posedge core_clk) disable iff (reset)
		(wrEn && bus.addr == OFF_KMB) |=> detEn[KEYS-1:DATA_W] == $past(bus.wdata[KMB_W-1:0]))
		else $error("high detect enables not applied");

	krc_bits_a: assert property (@(posedge core_clk) disable iff (reset)
		(krc_r & ~KRC_MASK) == ZERO8)
		else $error("reserved control bits set");

	kflag_set_a: assert property (@(posedge core_clk) disable iff (reset)
		(flagUse && edgeHit != '0) |=> (kflags_r & $past(edgeHit)) == $past(edgeHit))
		else $error("per-pin flag not set");

	// flags idle when not in use
	kflag_off_a: assert property (@(posedge core_clk) disable iff (reset)
		!flagUse |=> (kflags_r & ~$past(kflags_r)) == '0)
		else $error("per-pin flag set while unused");

	// status event only after an enabled hit
	req_cause_a: assert property (@(posedge core_clk) disable iff (reset)
		$rose(ists_r[EV_KEY]) |-> $past(|(edgeHit & detEn)))
		else $error("spurious event");

	irq_set_a: assert property (@(posedge core_clk) disable iff (reset)
		(anyHit && imsk_r[EV_KEY] && !(wrEn && bus.addr == OFF_IMSK)) |=> irq)
		else $error("interrupt not raised");

	sts_clear_a: assert property (@(posedge core_clk) disable iff (reset)
		(wrEn && bus.addr == OFF_ISTS && bus.wdata[EV_KEY] && !anyHit) |=> !ists_r[EV_KEY])
		else $error("status not cleared");
endmodule
`default_nettype wire

// *** shared/kirc_pkg.sv ***
package kirc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int KEY_W = 10;
	localparam logic [ADDR_W-1:0] OFF_DIR = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_IFL = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_MKL = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_PR0 = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_PR1 = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_KMA = 4'h5;
	localparam logic [ADDR_W-1:0] OFF_KMB = 4'h6;
	localparam logic [ADDR_W-1:0] OFF_KRC = 4'h7;
	localparam logic [ADDR_W-1:0] OFF_KFL = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_KFM = 4'h9;
	localparam logic [ADDR_W-1:0] OFF_ISTS = 4'hA;
	localparam logic [ADDR_W-1:0] OFF_IMSK = 4'hB;
	localparam int KEY_BIT = 4;
	localparam int EDGE_BIT = 0;
	localparam int FLAGUSE_BIT = 7;
	localparam int DIR_PINS = 2;
	localparam int KMB_W = 2;
	localparam logic [DATA_W-1:0] DIR_RST = 8'hFF;
	localparam logic [DATA_W-1:0] MASK_RST = 8'hFF;
	localparam logic [DATA_W-1:0] PRIO_RST = 8'hFF;
	localparam logic [DATA_W-1:0] ZERO8 = 8'h00;
	localparam logic [DATA_W-1:0] DIR_FIXED = 8'hFC;
	localparam logic [DATA_W-1:0] KRC_MASK = 8'h81;
	localparam int EV_KEY = 0;
	localparam int EV_W = 1;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} kirc_bus_t;
endpackage

// *** src/kirc_edge_detect.sv ***
`timescale 1ns/1ps
`default_nettype none
module kirc_edge_detect #(
	parameter int WIDTH = 10
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic             clkEn,
	input  wire logic [WIDTH-1:0] pinIn,
	input  wire logic [WIDTH-1:0] enable,
	input  wire logic             risingSel,
	output logic      [WIDTH-1:0] edgeHit
);
	logic [WIDTH-1:0] prev_r;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			prev_r <= '1;
		end else if (clkEn) begin
			prev_r <= pinIn;
		end
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_pin
			assign edgeHit[i] = enable[i] && clkEn &&
				(risingSel ? (pinIn[i] && !prev_r[i]) : (!pinIn[i] && prev_r[i]));
		end
	endgenerate
endmodule
`default_nettype wire

// *** verif/kirc_key_matrix.sv ***
`timescale 1ns/1ps
`default_nettype none
module kirc_key_matrix (
	input  wire logic [9:0] press,
	input  wire logic [1:0] retDrive,
	input  wire logic [1:0] oeN,
	input  wire logic [1:0] drv,
	output logic      [9:0] keyIn,
	output logic      [1:0] retPinIn
);
	// released keys pulled up, a pressed key pulls its return low
	assign keyIn = ~press;
	// a pin in output mode shows what the port drives
	assign retPinIn = (retDrive & oeN) | (drv & ~oeN);
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
	import kirc_pkg::*;
	logic              core_clk, reset, clkEn, keyIntReq, irq;
	kirc_bus_t         bus;
	logic [DATA_W-1:0] rdata, v;
	logic [KEY_W-1:0]  press, keyIn;
	logic [1:0]        retDrive, retPinIn, oeN, seen, keyPriority, retOut;
	int                num_errors, total_checks;
	// address, write data, expected read back
	logic [19:0]       rows [8] = '{20'h000FC, 20'h2EFEF, 20'h3EFEF, 20'h4FFFF,
		20'h7FF81, 20'hC5A00, 20'h50303, 20'h6FF03};

	kirc_top uut (.core_clk, .reset, .clkEn, .bus, .rdata, .keyIn, .retPinIn, .retPinOut(retOut),
		.retPinOe_n(oeN), .retPinSeen(seen), .keyIntReq, .keyPriority, .irq);
	kirc_key_matrix km (.press, .retDrive, .oeN, .drv(retOut), .keyIn, .retPinIn);

	initial begin
		core_clk = 0;
		forever #12.5 core_clk = ~core_clk;
	end

	task chk(input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task end_sim;
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk) bus <= '{a, 8'h00, 1'b0, 1'b0};
		#1;
	endtask

	task rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk) bus <= '{a, 8'h00, 1'b0, 1'b0};
		#1 d = rdata;
	endtask

	task key(input logic [9:0] p);
		@(posedge core_clk) press <= p;
		// scan gap, far shorter than the software wait
		repeat (3) @(posedge core_clk);
		#1;
	endtask

	initial begin
		#100us;
		num_errors++;
		end_sim;
	end

	initial begin
		reset = 1;
		clkEn = 1;
		bus = '0;
		press = '0;
		retDrive = 2'b01;
		retOut = 2'b00;
		repeat (3) @(posedge core_clk);
		reset <= 0;
		#1;
		chk(8'(oeN), 8'h03);
		chk(8'(seen), 8'h01);
		chk(8'(keyPriority), 8'h03);
		rd(OFF_IFL, v);
		chk(v, ZERO8);
		rd(OFF_MKL, v);
		chk(v, MASK_RST);
		$display("reset test done");
		foreach (rows[i]) begin
			wr(rows[i][19:16], rows[i][15:8]);
			rd(rows[i][19:16], v);
			chk(v, rows[i][7:0]);
		end
		chk(8'(oeN), 8'h00);
		@(posedge core_clk) retOut <= 2'b10;
		#1;
		chk(8'(seen), 8'h02);
		$display("register table done");
		for (int p = 0; p < 4; p++) begin
			wr(OFF_PR0, p[0] ? 8'hFF : 8'hEF);
			wr(OFF_PR1, p[1] ? 8'hFF : 8'hEF);
			chk(8'(keyPriority), 8'(p));
		end
		$display("priority test done");
		wr(OFF_IFL, ZERO8);
		wr(OFF_PR0, PRIO_RST);
		wr(OFF_PR1, PRIO_RST);
		// only pin 0 watched, falling edge
		wr(OFF_KRC, ZERO8);
		wr(OFF_KMA, 8'h01);
		wr(OFF_KMB, ZERO8);
		wr(OFF_IMSK, 8'h01);
		wr(OFF_MKL, 8'hEF);
		key(10'h002);
		chk(8'(keyIntReq), 8'h00);
		key(10'h003);
		chk(8'(keyIntReq), 8'h01);
		chk(8'(irq), 8'h01);
		rd(OFF_IFL, v);
		chk(v & 8'h10, 8'h10);
		wr(OFF_MKL, MASK_RST);
		chk(8'(keyIntReq), 8'h00);
		wr(OFF_ISTS, 8'h01);
		chk(8'(irq), 8'h00);
		wr(OFF_IFL, ZERO8);
		wr(OFF_MKL, 8'hEF);
		key(10'h000);
		chk(8'(keyIntReq), 8'h00);
		wr(OFF_KRC, 8'h01);
		key(10'h001);
		chk(8'(keyIntReq), 8'h00);
		key(10'h000);
		chk(8'(keyIntReq), 8'h01);
		$display("key test done");
		clkEn <= 0;
		wr(OFF_MKL, ZERO8);
		clkEn <= 1;
		rd(OFF_MKL, v);
		chk(v, 8'hEF);
		// per-pin flags on, rising edge, pins 0, 8 and 9 watched
		wr(OFF_KRC, 8'h81);
		wr(OFF_KMB, 8'h03);
		key(10'h200);
		key(10'h000);
		rd(OFF_KFM, v);
		chk(v, 8'h02);
		rd(OFF_KFL, v);
		chk(v, 8'h00);
		wr(OFF_KFM, 8'h02);
		rd(OFF_KFM, v);
		chk(v, 8'h00);
		rd(OFF_ISTS, v);
		chk(v, 8'h01);
		rd(OFF_IMSK, v);
		chk(v, 8'h01);
		$display("per-pin flag test done");
		reset <= 1;
		@(posedge core_clk) reset <= 0;
		#1;
		chk(8'(oeN), 8'h03);
		chk(8'(keyIntReq), 8'h00);
		chk(8'(irq), 8'h00);
		$display("freeze and reset test done");
		end_sim;
	end
endmodule
`default_nettype wire
